// >>> core/tos_defines.svh
// Offsets, field positions, reset values and timing counts of the thermal stage
`ifndef TOS_DEFINES_SVH
`define TOS_DEFINES_SVH

`define TOS_ADDR_W        8
`define TOS_OFS_CTRL      8'h00
`define TOS_OFS_ALARM1    8'h04
`define TOS_OFS_ALARM2    8'h08
`define TOS_OFS_HOLD      8'h0C
`define TOS_OFS_TRIP      8'h10
`define TOS_OFS_DELAY     8'h14
`define TOS_OFS_PICKUP    8'h18
`define TOS_OFS_STATUS    8'h1C
`define TOS_OFS_CNT0      8'h20
`define TOS_OFS_CNT_LAST  8'h30

`define TOS_CTRL_EN_LSB   0
`define TOS_CTRL_CLR_BIT  8

`define TOS_LVL_W         11
`define TOS_RST_ALARM1    11'h190
`define TOS_RST_ALARM2    11'h190
`define TOS_RST_HOLD      11'h320
`define TOS_RST_TRIP      11'h3E8
`define TOS_DELAY_W       20
`define TOS_RST_DELAY     20'h00000
`define TOS_RST_PICKUP    16'h0064

`define TOS_CUR_LIGHT     16'h0001
`define TOS_CUR_HIGH      16'h00C8
`define TOS_UNITY         16'h0064

`define TOS_CLK_PERIOD_NS 100
`define TOS_STEP_NS       5000000
`define TOS_STEP_CYC      (`TOS_STEP_NS / `TOS_CLK_PERIOD_NS)

`endif

// >>> core/tos_level_out.sv
// Enableable threshold output evaluated once per program cycle
`timescale 1ns/1ps
module tos_level_out #(
    parameter int CAP_W = 12,
    parameter int LVL_W = 11
) (
    input  logic             i_clk,
    input  logic             i_resetn,
    input  logic             i_ce,
    input  logic             i_cycle,
    input  logic             i_enable,
    input  logic [CAP_W-1:0] i_capacity,
    input  logic [LVL_W-1:0] i_level,
    output logic             o_active
);

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_active <= 1'b0;
        end else if (i_ce && i_cycle) begin
            o_active <= i_enable && (i_capacity >= CAP_W'(i_level));
        end
    end

endmodule // tos_level_out

// >>> core/tos_pkg.sv
// Types of the thermal stage output logic
package tos_pkg;

    typedef enum logic [2:0] {
        COND_NORMAL  = 3'h0,
        COND_ALARM1  = 3'h1,
        COND_ALARM2  = 3'h2,
        COND_HOLD    = 3'h3,
        COND_TRIP    = 3'h4,
        COND_BLOCKED = 3'h5
    } tos_cond_t;

    typedef enum logic [1:0] {
        LOAD_LIGHT  = 2'h0,
        LOAD_NORMAL = 2'h1,
        LOAD_OVER   = 2'h2,
        LOAD_HIGH   = 2'h3
    } tos_load_t;

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_TIMING  = 2'b01,
        ST_TRIPPED = 2'b11,
        ST_BLOCKED = 2'b10
    } tos_state_t;

endpackage

// >>> core/tos_thermal_stage.sv
// Thermal stage outputs, trip timing, supervision and APB registers
`timescale 1ns/1ps
`include "tos_defines.svh"
module tos_thermal_stage
    import tos_pkg::*;
#(
    parameter int STEP_CYC = `TOS_STEP_CYC,
    parameter int CNT_W    = 16,
    parameter int CAP_W    = 12
) (
    input  logic                   i_clk,
    input  logic                   i_resetn,
    input  logic                   i_ce,
    input  logic                   i_psel,
    input  logic                   i_penable,
    input  logic                   i_pwrite,
    input  logic [`TOS_ADDR_W-1:0] i_paddr,
    input  logic [31:0]            i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  logic                   i_cycle,
    input  logic                   i_block,
    input  logic [CAP_W-1:0]       i_capacity,
    input  logic [15:0]            i_current,
    input  logic [15:0]            i_service_factor,
    input  logic                   i_sf_valid,
    input  logic [15:0]            i_amb_k,
    input  logic                   i_amb_valid,
    input  logic [15:0]            i_inom,
    input  logic                   i_inom_valid,
    input  logic                   i_ambk_consistent,
    output logic                   o_alarm1,
    output logic                   o_alarm2,
    output logic                   o_restart_hold,
    output logic                   o_trip,
    output logic                   o_start,
    output logic                   o_blocked,
    output logic [2:0]             o_stage_condition_code,
    output logic [1:0]             o_load_class,
    output logic [3:0]             o_setting_fault_flag,
    output logic [15:0]            o_service_factor_used,
    output logic [15:0]            o_amb_k_used,
    output logic [15:0]            o_inom_used,
    output logic [4:0]             o_event_on,
    output logic [4:0]             o_event_off,
    output logic [31:0]            o_event_stamp
);

    localparam int PRE_W = (STEP_CYC > 1) ? $clog2(STEP_CYC) : 1;
    localparam int NCNT  = 5;

    function automatic logic tos_mapped(input logic [`TOS_ADDR_W-1:0] a);
        tos_mapped = (a[1:0] == 2'b00) && (a <= `TOS_OFS_CNT_LAST);
    endfunction

    logic [3:0]              enable;
    logic [`TOS_LVL_W-1:0]   level [4];
    logic [`TOS_DELAY_W-1:0] extra_trip_delay;
    logic [15:0]             pickup_cur;
    logic                    rd_ok;
    logic                    wr_acc;
    logic                    cnt_clr;
    logic [PRE_W-1:0]        pre;
    logic                    tick;
    logic [31:0]             stamp;
    logic [`TOS_DELAY_W-1:0] delay_cnt;
    tos_state_t              state;
    logic                    pickup;
    logic                    blk_smp;
    logic [2:0]              lvl_act;
    logic [4:0]              sig;
    logic [4:0]              sig_prev;
    logic [CNT_W-1:0]        counter [NCNT];
    logic [31:0]             rd_mux;
    logic [2:0]              next_cond;
    logic [1:0]              next_load;

    // APB slave: read data captured in setup, zero wait states
    assign o_pready  = rd_ok && i_ce;
    assign o_pslverr = o_pready && !tos_mapped(i_paddr);
    assign wr_acc    = i_psel && i_penable && o_pready && i_pwrite && tos_mapped(i_paddr);
    assign cnt_clr   = wr_acc && (i_paddr == `TOS_OFS_CTRL) && i_pwdata[`TOS_CTRL_CLR_BIT];

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rd_ok    <= 1'b0;
            o_prdata <= 32'h00000000;
        end else if (i_ce) begin
            if (i_psel && i_penable && rd_ok) begin
                rd_ok <= 1'b0;
            end else if (i_psel) begin
                rd_ok    <= 1'b1;
                o_prdata <= rd_mux;
            end
        end
    end

    // Settings written live while the stage runs
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            enable           <= 4'h0;
            level[0]         <= `TOS_RST_ALARM1;
            level[1]         <= `TOS_RST_ALARM2;
            level[2]         <= `TOS_RST_HOLD;
            level[3]         <= `TOS_RST_TRIP;
            extra_trip_delay <= `TOS_RST_DELAY;
            pickup_cur       <= `TOS_RST_PICKUP;
        end else if (i_ce && wr_acc) begin
            unique case (i_paddr)
                `TOS_OFS_CTRL:   enable           <= i_pwdata[`TOS_CTRL_EN_LSB +: 4];
                `TOS_OFS_ALARM1: level[0]         <= i_pwdata[`TOS_LVL_W-1:0];
                `TOS_OFS_ALARM2: level[1]         <= i_pwdata[`TOS_LVL_W-1:0];
                `TOS_OFS_HOLD:   level[2]         <= i_pwdata[`TOS_LVL_W-1:0];
                `TOS_OFS_TRIP:   level[3]         <= i_pwdata[`TOS_LVL_W-1:0];
                `TOS_OFS_DELAY:  extra_trip_delay <= i_pwdata[`TOS_DELAY_W-1:0];
                `TOS_OFS_PICKUP: pickup_cur       <= i_pwdata[15:0];
                default: ;
            endcase
        end
    end

    always_comb begin
        rd_mux = 32'h00000000;
        if (i_paddr >= `TOS_OFS_CNT0 && tos_mapped(i_paddr)) begin
            rd_mux = 32'(counter[3'(i_paddr[4:2])]);
        end else begin
            unique case (i_paddr)
                `TOS_OFS_CTRL:   rd_mux = {28'h0000000, enable};
                `TOS_OFS_ALARM1: rd_mux = 32'(level[0]);
                `TOS_OFS_ALARM2: rd_mux = 32'(level[1]);
                `TOS_OFS_HOLD:   rd_mux = 32'(level[2]);
                `TOS_OFS_TRIP:   rd_mux = 32'(level[3]);
                `TOS_OFS_DELAY:  rd_mux = 32'(extra_trip_delay);
                `TOS_OFS_PICKUP: rd_mux = {16'h0000, pickup_cur};
                `TOS_OFS_STATUS: rd_mux = {11'h000, sig, 2'h0, blk_smp, o_start,
                                           o_setting_fault_flag, 2'h0, o_load_class,
                                           1'b0, o_stage_condition_code};
                default:         rd_mux = 32'h00000000;
            endcase
        end
    end

    // Time base: one tick per delay step, also the event time stamp
    assign tick = (pre == PRE_W'(STEP_CYC - 1));

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            pre   <= '0;
            stamp <= 32'h00000000;
        end else if (i_ce) begin
            if (tick) begin
                pre   <= '0;
                stamp <= stamp + 32'h00000001;
            end else begin
                pre <= pre + PRE_W'(1);
            end
        end
    end

    // Level outputs: alarm one, alarm two, restart hold
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_lvl
            tos_level_out #(
                .CAP_W (CAP_W),
                .LVL_W (`TOS_LVL_W)
            ) u_lvl (
                .i_clk      (i_clk),
                .i_resetn   (i_resetn),
                .i_ce       (i_ce),
                .i_cycle    (i_cycle),
                .i_enable   (enable[g]),
                .i_capacity (i_capacity),
                .i_level    (level[g]),
                .o_active   (lvl_act[g])
            );
        end
    endgenerate

    assign o_alarm1       = lvl_act[0];
    assign o_alarm2       = lvl_act[1];
    assign o_restart_hold = lvl_act[2];

    // Trip pick-up requires its enable
    assign pickup = enable[3] && (i_capacity >= CAP_W'(level[3]));

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            blk_smp <= 1'b0;
        end else if (i_ce && i_cycle) begin
            blk_smp <= i_block;
        end
    end

    // Trip sequence; evaluated only at a program cycle using the block level then
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= ST_IDLE;
        end else if (i_ce && i_cycle) begin
            unique case (state)
                ST_IDLE: begin
                    if (pickup && i_block) begin
                        state <= ST_BLOCKED;
                    end else if (pickup) begin
                        state <= (extra_trip_delay == '0) ? ST_TRIPPED : ST_TIMING;
                    end
                end
                ST_TIMING: begin
                    if (!pickup || i_block) begin
                        state <= ST_IDLE;
                    end else if (delay_cnt >= extra_trip_delay) begin
                        state <= ST_TRIPPED;
                    end
                end
                ST_TRIPPED: begin
                    if (!pickup) begin
                        state <= ST_IDLE;
                    end else if (i_block) begin
                        state <= ST_BLOCKED;
                    end
                end
                ST_BLOCKED: begin
                    if (!pickup) begin
                        state <= ST_IDLE;
                    end else if (!i_block) begin
                        state <= (extra_trip_delay == '0) ? ST_TRIPPED : ST_TIMING;
                    end
                end
            endcase
        end
    end

    // Extra delay counted in steps while timing, cleared otherwise
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            delay_cnt <= '0;
        end else if (i_ce) begin
            if (state != ST_TIMING) begin
                delay_cnt <= '0;
            end else if (tick && delay_cnt != '1) begin
                delay_cnt <= delay_cnt + `TOS_DELAY_W'(1);
            end
        end
    end

    assign o_start   = (state == ST_TIMING) || (state == ST_TRIPPED);
    assign o_trip    = (state == ST_TRIPPED);
    assign o_blocked = (state == ST_BLOCKED);
    assign sig       = {o_blocked, o_trip, o_restart_hold, o_alarm2, o_alarm1};

    // Condition code by priority; start is not encoded, so normal also while only start is driven
    always_comb begin
        next_cond = COND_NORMAL;
        if (o_blocked) begin
            next_cond = COND_BLOCKED;
        end else if (o_trip) begin
            next_cond = COND_TRIP;
        end else if (o_restart_hold) begin
            next_cond = COND_HOLD;
        end else if (o_alarm2) begin
            next_cond = COND_ALARM2;
        end else if (o_alarm1) begin
            next_cond = COND_ALARM1;
        end
    end

    always_comb begin
        next_load = LOAD_NORMAL;
        if (i_current < `TOS_CUR_LIGHT) begin
            next_load = LOAD_LIGHT;
        end else if (i_current >= `TOS_CUR_HIGH) begin
            next_load = LOAD_HIGH;
        end else if (i_current >= pickup_cur) begin
            next_load = LOAD_OVER;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_stage_condition_code <= COND_NORMAL;
            o_load_class           <= LOAD_LIGHT;
        end else if (i_ce) begin
            o_stage_condition_code <= next_cond;
            o_load_class           <= next_load;
        end
    end

    // Setting supervision: flag each fault while it stands, substitute unity for an invalid setting
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_setting_fault_flag  <= 4'h0;
            o_service_factor_used <= `TOS_UNITY;
            o_amb_k_used          <= `TOS_UNITY;
            o_inom_used           <= `TOS_UNITY;
        end else if (i_ce) begin
            o_setting_fault_flag[0] <= !i_sf_valid;
            o_setting_fault_flag[1] <= !i_amb_valid;
            o_setting_fault_flag[2] <= !i_inom_valid;
            o_setting_fault_flag[3] <= !i_ambk_consistent;
            o_service_factor_used   <= i_sf_valid ? i_service_factor : `TOS_UNITY;
            o_amb_k_used            <= i_amb_valid ? i_amb_k : `TOS_UNITY;
            o_inom_used             <= i_inom_valid ? i_inom : `TOS_UNITY;
        end
    end

    // Events on both edges of each signal, stamped with the step count
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sig_prev      <= 5'h00;
            o_event_on    <= 5'h00;
            o_event_off   <= 5'h00;
            o_event_stamp <= 32'h00000000;
        end else if (i_ce) begin
            sig_prev      <= sig;
            o_event_on    <= sig & ~sig_prev;
            o_event_off   <= ~sig & sig_prev;
            o_event_stamp <= stamp;
        end
    end

    // Activation counters; a count in the clearing cycle wins
    generate
        for (g = 0; g < NCNT; g++) begin : g_cnt
            always_ff @(posedge i_clk) begin
                if (!i_resetn) begin
                    counter[g] <= '0;
                end else if (i_ce) begin
                    if (sig[g] && !sig_prev[g]) begin
                        counter[g] <= cnt_clr ? CNT_W'(1) : counter[g] + CNT_W'(1);
                    end else if (cnt_clr) begin
                        counter[g] <= '0;
                    end
                end
            end
        end
    endgenerate

endmodule // tos_thermal_stage

// >>> tb/tb.sv
// Self-checking bench of the thermal stage output logic
`timescale 1ns/1ps
`include "tos_defines.svh"
module tb
    import tos_pkg::*;
;
    typedef struct packed {
        logic [3:0]  en;
        logic [11:0] cap;
        logic [2:0]  lv;
    } tos_row_t;

    logic        i_clk = 1'b0, i_resetn = 1'b0, i_ce = 1'b1, i_cycle = 1'b0, i_block = 1'b0;
    logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, e;
    logic        i_sf_valid = 1'b1, i_amb_valid = 1'b1, i_inom_valid = 1'b1;
    logic        i_ambk_consistent = 1'b1;
    logic        o_pready, o_pslverr, o_alarm1, o_alarm2, o_restart_hold, o_trip, o_start;
    logic        o_blocked;
    logic [7:0]  i_paddr = 8'h00;
    logic [11:0] i_capacity = 12'h000;
    logic [15:0] i_current = 16'h0000, i_service_factor = 16'h0096, i_amb_k = 16'h0050;
    logic [15:0] i_inom = 16'h00C8, o_service_factor_used, o_amb_k_used, o_inom_used;
    logic [31:0] i_pwdata = 32'h0, o_prdata, o_event_stamp, q;
    logic [2:0]  o_stage_condition_code, prev;
    logic [1:0]  o_load_class;
    logic [3:0]  o_setting_fault_flag;
    logic [4:0]  o_event_on, o_event_off;
    int          bad_count = 0, samples_checked = 0;
    int          ups [3] = '{0, 0, 0};

    // Alarm two level is moved to 600 before these rows
    tos_row_t    rows [9] = '{
        '{4'h7, 12'h18F, 3'h0}, '{4'h7, 12'h190, 3'h1}, '{4'h7, 12'h257, 3'h1},
        '{4'h7, 12'h258, 3'h3}, '{4'h7, 12'h320, 3'h7}, '{4'h7, 12'h31F, 3'h3},
        '{4'h5, 12'h320, 3'h5}, '{4'h0, 12'h3E8, 3'h0}, '{4'h7, 12'h3E8, 3'h7}};
    logic [7:0]  ra [7] = '{`TOS_OFS_CTRL, `TOS_OFS_ALARM1, `TOS_OFS_ALARM2, `TOS_OFS_HOLD,
                            `TOS_OFS_TRIP, `TOS_OFS_DELAY, `TOS_OFS_PICKUP};
    logic [31:0] rv [7] = '{32'h0, 32'h190, 32'h190, 32'h320, 32'h3E8, 32'h0, 32'h64};
    logic [15:0] cur [4] = '{16'h0000, 16'h0032, 16'h0096, 16'h00FA};

    tos_thermal_stage #(.STEP_CYC(4)) tos_thermal_stage_i (.*);

    always #50 i_clk = ~i_clk;

    task automatic chk(input logic [31:0] got, input logic [31:0] x);
        samples_checked++;
        if (got !== x) begin
            bad_count++;
            $display("BAD %0t got %h expected %h", $time, got, x);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        q = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask

    task automatic pulse(input logic [11:0] cap, input logic blk);
        @(posedge i_clk);
        i_capacity <= cap;
        i_block <= blk;
        i_cycle <= 1'b1;
        @(posedge i_clk);
        i_cycle <= 1'b0;
        @(negedge i_clk);
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge i_clk);
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge i_clk);
        i_resetn <= 1'b1;
        apb(1'b1, `TOS_OFS_ALARM2, 32'h258);
        prev = 3'h0;
        foreach (rows[r]) begin
            apb(1'b1, `TOS_OFS_CTRL, {28'h0, rows[r].en});
            pulse(rows[r].cap, 1'b0);
            chk({o_restart_hold, o_alarm2, o_alarm1}, rows[r].lv);
            for (int j = 0; j < 3; j++) ups[j] += rows[r].lv[j] & ~prev[j];
            prev = rows[r].lv;
        end
        @(negedge i_clk);
        chk(o_stage_condition_code, COND_HOLD);
        for (int j = 0; j < 3; j++) rd_chk(`TOS_OFS_CNT0 + 8'(4 * j), ups[j]);
        apb(1'b1, `TOS_OFS_CTRL, 32'h107);
        rd_chk(`TOS_OFS_CNT0, 32'h0);
        // Second reset in mid-run must restore the default of every setting register
        @(posedge i_clk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_resetn <= 1'b1;
        foreach (ra[k]) rd_chk(ra[k], rv[k]);
        apb(1'b0, 8'h34, 32'h0);
        chk(q, 32'h0);
        chk(e, 32'h1);
        pulse(12'h3E8, 1'b0);
        chk({o_trip, o_start, o_restart_hold, o_alarm2, o_alarm1}, 32'h0);
        apb(1'b1, `TOS_OFS_CTRL, 32'h8);
        pulse(12'h3E8, 1'b0);
        chk({o_trip, o_start}, 32'h3);
        pulse(12'h3E7, 1'b0);
        chk({o_trip, o_start}, 32'h0);
        apb(1'b1, `TOS_OFS_DELAY, 32'h3);
        pulse(12'h3E8, 1'b0);
        chk({o_trip, o_start}, 32'h1);
        pulse(12'h3E8, 1'b0);
        chk({o_trip, o_start}, 32'h1);
        repeat (16) @(posedge i_clk);
        pulse(12'h3E8, 1'b0);
        chk({o_trip, o_start}, 32'h3);
        pulse(12'h3E8, 1'b1);
        chk({o_blocked, o_trip, o_start}, 32'h4);
        pulse(12'h3E8, 1'b0);
        chk({o_blocked, o_start}, 32'h1);
        pulse(12'h3E8, 1'b1);
        chk({o_blocked, o_start}, 32'h0);
        pulse(12'h3E8, 1'b1);
        chk({o_blocked, o_start}, 32'h2);
        @(posedge i_clk);
        i_block <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk(o_blocked, 32'h1);
        chk(o_stage_condition_code, COND_BLOCKED);
        rd_chk(`TOS_OFS_CNT_LAST, 32'h2);
        rd_chk(`TOS_OFS_STATUS, 32'h00102005);
        // Stamp advances one per step of four clocks
        @(negedge i_clk);
        q = o_event_stamp;
        repeat (8) @(negedge i_clk);
        chk(o_event_stamp - q, 32'h2);
        // Clock enable low freezes the stage despite a program cycle
        @(posedge i_clk);
        i_ce <= 1'b0;
        pulse(12'h000, 1'b0);
        chk(o_blocked, 32'h1);
        @(posedge i_clk);
        i_ce <= 1'b1;
        foreach (cur[k]) begin
            @(posedge i_clk);
            i_current <= cur[k];
            @(posedge i_clk);
            @(negedge i_clk);
            chk(o_load_class, k);
        end
        for (int k = 0; k < 5; k++) begin
            @(posedge i_clk);
            i_sf_valid <= (k != 0);
            i_amb_valid <= (k != 1);
            i_inom_valid <= (k != 2);
            i_ambk_consistent <= (k != 3);
            @(posedge i_clk);
            @(negedge i_clk);
            chk(o_setting_fault_flag, (k < 4) ? 32'h1 << k : 32'h0);
            chk(o_service_factor_used, (k == 0) ? 32'h64 : 32'h96);
            chk(o_amb_k_used, (k == 1) ? 32'h64 : 32'h50);
            chk(o_inom_used, (k == 2) ? 32'h64 : 32'hC8);
        end
        give_verdict();
    end
endmodule // tb

// >>> tb/tos_thermal_stage_assertions.sv
// Concurrent checks on the thermal stage ports
`timescale 1ns/1ps
module tos_thermal_stage_assertions
    import tos_pkg::*;
(
    input logic        i_clk,
    input logic        i_resetn,
    input logic        i_ce,
    input logic        i_cycle,
    input logic        i_block,
    input logic [15:0] i_current,
    input logic [15:0] i_service_factor,
    input logic        i_sf_valid,
    input logic        i_amb_valid,
    input logic        i_inom_valid,
    input logic        i_ambk_consistent,
    input logic        o_alarm1,
    input logic        o_alarm2,
    input logic        o_restart_hold,
    input logic        o_trip,
    input logic        o_start,
    input logic        o_blocked,
    input logic [2:0]  o_stage_condition_code,
    input logic [1:0]  o_load_class,
    input logic [3:0]  o_setting_fault_flag,
    input logic [15:0] o_service_factor_used,
    input logic [4:0]  o_event_on,
    input logic [4:0]  o_event_off
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    logic       cyc;
    logic [4:0] sig;
    assign cyc = i_cycle && i_ce;
    assign sig = {o_blocked, o_trip, o_restart_hold, o_alarm2, o_alarm1};

    // Priority blocked, trip, hold, alarm two, alarm one
    function automatic logic [2:0] cond_of(input logic [4:0] s);
        if (s[4]) return COND_BLOCKED;
        if (s[3]) return COND_TRIP;
        if (s[2]) return COND_HOLD;
        if (s[1]) return COND_ALARM2;
        if (s[0]) return COND_ALARM1;
        return COND_NORMAL;
    endfunction

    property p_hold_off_cycle;
        !cyc |=> $stable({sig, o_start});
    endproperty
    a_hold_off_cycle: assert property (p_hold_off_cycle)
        else $error("stage outputs moved outside a program cycle");

    property p_cond;
        $past(i_resetn) && $past(i_ce) |-> o_stage_condition_code == cond_of($past(sig));
    endproperty
    a_cond: assert property (p_cond)
        else $error("condition code does not follow the outputs");

    property p_event_on;
        $past(i_resetn, 2) && $past(i_resetn) |-> o_event_on == ($past(sig) & ~$past(sig, 2));
    endproperty
    a_event_on: assert property (p_event_on)
        else $error("assertion event pulse wrong");

    property p_event_off;
        $past(i_resetn, 2) && $past(i_resetn) |-> o_event_off == (~$past(sig) & $past(sig, 2));
    endproperty
    a_event_off: assert property (p_event_off)
        else $error("release event pulse wrong");

    property p_block_stops;
        cyc && i_block && !o_start |=> !o_start;
    endproperty
    a_block_stops: assert property (p_block_stops)
        else $error("blocked pick-up started timing");

    property p_block_clears;
        cyc && i_block && o_start && !o_trip |=> !o_start && !o_blocked;
    endproperty
    a_block_clears: assert property (p_block_clears)
        else $error("block during timing did not release start");

    property p_unblock;
        cyc && !i_block && o_blocked |=> !o_blocked;
    endproperty
    a_unblock: assert property (p_unblock)
        else $error("blocked state kept without block");

    property p_load;
        $past(i_resetn) && $past(i_ce) |->
            (($past(i_current) == 16'h0000) == (o_load_class == LOAD_LIGHT)) &&
            (($past(i_current) >= 16'h00C8) == (o_load_class == LOAD_HIGH));
    endproperty
    a_load: assert property (p_load)
        else $error("load class wrong");

    property p_faults;
        $past(i_resetn) && $past(i_ce) |-> o_setting_fault_flag ==
            ~$past({i_ambk_consistent, i_inom_valid, i_amb_valid, i_sf_valid});
    endproperty
    a_faults: assert property (p_faults)
        else $error("setting fault flags wrong");

    property p_sf_used;
        $past(i_resetn) && $past(i_ce) |-> o_service_factor_used ==
            ($past(i_sf_valid) ? $past(i_service_factor) : 16'h0064);
    endproperty
    a_sf_used: assert property (p_sf_used)
        else $error("service factor substitute wrong");
endmodule // tos_thermal_stage_assertions

bind tos_thermal_stage tos_thermal_stage_assertions tos_thermal_stage_assertions_i (.*);
